// ==== pkg/imd_pkg.sv ====
// package for the internal memory map decoder: windows, views, decode result carrier
// assumes byte-free word addressing of a 32-bit address space
package imd_pkg;

  // ==========================================================
  // address views and targets
  typedef enum logic [2:0] {
    IMD_VIEW_NONE,
    IMD_VIEW_IOREG,
    IMD_VIEW_LONG,
    IMD_VIEW_EXT,
    IMD_VIEW_NORMAL,
    IMD_VIEW_SHORT
  } imd_view_t;

  typedef enum logic [2:0] {
    IMD_TGT_NONE,
    IMD_TGT_IOREG,
    IMD_TGT_ROM0,
    IMD_TGT_SRAM0,
    IMD_TGT_ROM1,
    IMD_TGT_SRAM1,
    IMD_TGT_SRAM2,
    IMD_TGT_SRAM3
  } imd_target_t;

  // one decoded access as seen by a memory block
  typedef struct packed {
    logic        valid;
    imd_target_t target;
    imd_view_t   view;
    logic [19:0] offset;   // word offset inside the block window
  } imd_decode_t;

  // ==========================================================
  // window table: start, end, target, view
  localparam int IMD_WIN_COUNT = 25;
  localparam logic [31:0] IMD_WIN_LO [IMD_WIN_COUNT] = '{
    32'h0000_0000,
    32'h0004_0000, 32'h0004_C000, 32'h0005_0000, 32'h0005_C000, 32'h0006_0000, 32'h0007_0000,
    32'h0008_0000, 32'h0009_0000, 32'h000A_0000, 32'h000B_0000, 32'h000C_0000, 32'h000E_0000,
    32'h0008_0000, 32'h0009_8000, 32'h000A_0000, 32'h000B_8000, 32'h000C_0000, 32'h000E_0000,
    32'h0010_0000, 32'h0013_0000, 32'h0014_0000, 32'h0017_0000, 32'h0018_0000, 32'h001C_0000
  };
  localparam logic [31:0] IMD_WIN_HI [IMD_WIN_COUNT] = '{
    32'h0003_FFFF,
    32'h0004_7FFF, 32'h0004_FFFF, 32'h0005_7FFF, 32'h0005_FFFF, 32'h0006_1FFF, 32'h0007_1FFF,
    32'h0008_AAA9, 32'h0009_5554, 32'h000A_AAA9, 32'h000B_5554, 32'h000C_2AA9, 32'h000E_2AA9,
    32'h0008_FFFF, 32'h0009_FFFF, 32'h000A_FFFF, 32'h000B_FFFF, 32'h000C_3FFF, 32'h000E_3FFF,
    32'h0011_FFFF, 32'h0013_FFFF, 32'h0015_FFFF, 32'h0017_FFFF, 32'h0018_7FFF, 32'h001C_7FFF
  };
  localparam imd_target_t IMD_WIN_TGT [IMD_WIN_COUNT] = '{
    IMD_TGT_IOREG,
    IMD_TGT_ROM0, IMD_TGT_SRAM0, IMD_TGT_ROM1, IMD_TGT_SRAM1, IMD_TGT_SRAM2, IMD_TGT_SRAM3,
    IMD_TGT_ROM0, IMD_TGT_SRAM0, IMD_TGT_ROM1, IMD_TGT_SRAM1, IMD_TGT_SRAM2, IMD_TGT_SRAM3,
    IMD_TGT_ROM0, IMD_TGT_SRAM0, IMD_TGT_ROM1, IMD_TGT_SRAM1, IMD_TGT_SRAM2, IMD_TGT_SRAM3,
    IMD_TGT_ROM0, IMD_TGT_SRAM0, IMD_TGT_ROM1, IMD_TGT_SRAM1, IMD_TGT_SRAM2, IMD_TGT_SRAM3
  };
  // extended windows overlap the normal ones; earlier entries win, so ext is listed first
  localparam imd_view_t IMD_WIN_VIEW [IMD_WIN_COUNT] = '{
    IMD_VIEW_IOREG,
    IMD_VIEW_LONG, IMD_VIEW_LONG, IMD_VIEW_LONG, IMD_VIEW_LONG, IMD_VIEW_LONG, IMD_VIEW_LONG,
    IMD_VIEW_EXT, IMD_VIEW_EXT, IMD_VIEW_EXT, IMD_VIEW_EXT, IMD_VIEW_EXT, IMD_VIEW_EXT,
    IMD_VIEW_NORMAL, IMD_VIEW_NORMAL, IMD_VIEW_NORMAL, IMD_VIEW_NORMAL, IMD_VIEW_NORMAL,
    IMD_VIEW_NORMAL,
    IMD_VIEW_SHORT, IMD_VIEW_SHORT, IMD_VIEW_SHORT, IMD_VIEW_SHORT, IMD_VIEW_SHORT,
    IMD_VIEW_SHORT
  };

  // ==========================================================
  // circular buffer address unit
  localparam int IMD_BUF_SETS    = 16;        // per register bank
  localparam int IMD_BUF_BANKS   = 2;         // primary and secondary
  localparam int IMD_SET_IDX_W   = 5;         // selects one of 32 buffers
  localparam logic [31:0] IMD_PTR_RESET = 32'h0000_0000;

endpackage

// ==== design/imd_decoder.sv ====
// internal memory map decoder with two core buses, one io_processor port, and
// the circular buffer data_address_unit driving the data_memory_bus address.
// assumes requesters present one access per cycle; all inputs synchronous to ref_clk.
//
// Overview of operation
// R1: addresses 0x0-0x3FFFF go to io_processor registers, never memory blocks
// R2: every block is reachable in four views; long-word view windows as tabulated
// R3: normal-word view maps blocks at their 32-bit windows, one word each
// R4: short-word view maps blocks at 16-bit windows, one half-word each
// R5: 48-bit view maps blocks densely at their extended windows
// R6: reserved holes and everything above 0x1FFFFF select no block
// R7: each block serves core and io_processor in one cycle, independently
// R8: two core transfers plus one io_processor transfer complete together
// R9: sram capacity bounds of 96K normal, 192K short, 64K extended words
// R10: three megabits sram and four megabits rom, holding code or data
// R11: address unit keeps 32 circular buffers in primary and secondary banks
// R12: pointer wraps into its buffer on each access with no extra cycle
// R13: buffer base and end may sit at any address without alignment
// R14: instruction fetches return 48-bit words through the extended view
// R15: dual transfer single cycle only when buses use different blocks
// R16: leaving base..base+length adds or subtracts length to re-enter
`timescale 1ns/1ns
module imd_decoder #(
  parameter int ADDR_W = 32
) (
  input  wire logic                         ref_clk,
  input  wire logic                         reset_n,
  // program_memory_bus request (address given directly)
  input  wire logic                         pm_req,
  input  wire logic [ADDR_W-1:0]            pm_addr,
  input  wire logic                         pm_fetch,
  // data_memory_bus request through the data_address_unit
  input  wire logic                         dm_req,
  input  wire logic [imd_pkg::IMD_SET_IDX_W-1:0] dm_set,
  input  wire logic signed [31:0]           dm_modify,
  // data_address_unit set load
  input  wire logic                         set_load,
  input  wire logic [imd_pkg::IMD_SET_IDX_W-1:0] set_idx,
  input  wire logic [31:0]                  set_base,
  input  wire logic [31:0]                  set_length,
  // io_processor request
  input  wire logic                         io_req,
  input  wire logic [ADDR_W-1:0]            io_addr,
  // decode results, one cycle after the request
  output imd_pkg::imd_decode_t              pm_dec,
  output imd_pkg::imd_decode_t              dm_dec,
  output imd_pkg::imd_decode_t              io_dec,
  output logic [ADDR_W-1:0]                 dm_addr,
  output logic                              pm_fetch_ok,
  output logic                              dual_conflict
);

  // ==========================================================
  // address decode function
  // ranges are compared whole so any holes fall out as unmapped
  // block storage and its capacity sit outside; only their windows are decoded  // R9 R10
  function automatic imd_pkg::imd_decode_t decode(input logic req, input logic [31:0] a);
    imd_pkg::imd_decode_t d;
    logic                 hit;
    d   = '0;
    hit = 1'b0;
    for (int w = 0; w < imd_pkg::IMD_WIN_COUNT; w++) begin
      if (!hit && a >= imd_pkg::IMD_WIN_LO[w] && a <= imd_pkg::IMD_WIN_HI[w]) begin
        hit      = 1'b1;
        d.target = imd_pkg::IMD_WIN_TGT[w];        // R1 R2 R3 R4 R5
        d.view   = imd_pkg::IMD_WIN_VIEW[w];
        d.offset = 20'(a - imd_pkg::IMD_WIN_LO[w]);
      end
    end
    d.valid = req & hit;                           // R6
    if (!hit) begin
      d.target = imd_pkg::IMD_TGT_NONE;
      d.view   = imd_pkg::IMD_VIEW_NONE;
    end
    return d;
  endfunction

  // ==========================================================
  // circular buffer register sets
  // 32 sets cover both banks; bank select is the top index bit
  localparam int NSETS = imd_pkg::IMD_BUF_SETS * imd_pkg::IMD_BUF_BANKS;
  localparam int IDX_W = imd_pkg::IMD_SET_IDX_W;
  logic [31:0] ptr  [NSETS];
  logic [31:0] base [NSETS];
  logic [31:0] len  [NSETS];
  logic [31:0] next_ptr;
  logic [31:0] cur_ptr;
  logic [31:0] cur_base;
  logic [31:0] cur_len;
  logic [32:0] stepped;
  logic [32:0] span_end;

  assign cur_ptr  = ptr[dm_set];
  assign cur_base = base[dm_set];
  assign cur_len  = len[dm_set];

  // post-modify with wrap; wide math so base may sit anywhere
  always_comb begin
    stepped  = {1'b0, cur_ptr} + 33'(dm_modify);
    span_end = {1'b0, cur_base} + {1'b0, cur_len};
    if (cur_len == 32'h0000_0000) begin
      next_ptr = stepped[31:0];                     // length zero disables wrapping
    end else if (stepped < {1'b0, cur_base} || (dm_modify < 0 && stepped[32])) begin
      // underflow past zero is tested first: its 33-bit sum looks huge
      next_ptr = 32'(stepped + {1'b0, cur_len});    // R16
    end else if (stepped >= span_end) begin
      next_ptr = 32'(stepped - {1'b0, cur_len});    // R12 R16
    end else begin
      next_ptr = stepped[31:0];                     // R13
    end
  end

  // one generate per set: load, then advance on use
  generate
    for (genvar s = 0; s < NSETS; s++) begin : g_set
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          ptr[s]  <= imd_pkg::IMD_PTR_RESET;
          base[s] <= imd_pkg::IMD_PTR_RESET;
          len[s]  <= imd_pkg::IMD_PTR_RESET;
        end else if (set_load && set_idx == IDX_W'(s)) begin
          ptr[s]  <= set_base;                      // R11
          base[s] <= set_base;
          len[s]  <= set_length;
        end else if (dm_req && dm_set == IDX_W'(s)) begin
          ptr[s]  <= next_ptr;                      // R12
        end
      end
    end
  endgenerate

  // ==========================================================
  // three independent decode ports, registered outputs
  // each port has its own decoder so no requester waits on another
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pm_dec  <= '0;
      dm_dec  <= '0;
      io_dec  <= '0;
      dm_addr <= '0;
    end else begin
      pm_dec  <= decode(pm_req, pm_addr);           // R7 R8
      dm_dec  <= decode(dm_req, cur_ptr);           // R7 R8
      io_dec  <= decode(io_req, io_addr);           // R7 R8
      dm_addr <= cur_ptr;
    end
  end

  // ==========================================================
  // fetch view check and bus conflict flag
  // a fetch outside the 48-bit view is flagged, not blocked; the sequencer decides
  imd_pkg::imd_decode_t pm_now;
  imd_pkg::imd_decode_t dm_now;
  assign pm_now = decode(pm_req, pm_addr);
  assign dm_now = decode(dm_req, cur_ptr);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pm_fetch_ok <= 1'b0;
    end else begin
      pm_fetch_ok <= pm_fetch && pm_now.valid
                     && pm_now.view == imd_pkg::IMD_VIEW_EXT;   // R14
    end
  end

  // both core buses on one block costs the single cycle guarantee
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dual_conflict <= 1'b0;
    end else begin
      dual_conflict <= pm_now.valid && dm_now.valid
                       && pm_now.target == dm_now.target
                       && pm_now.target != imd_pkg::IMD_TGT_IOREG;  // R15
    end
  end

  // ==========================================================
  // assertions
  // window decode per view; the io_processor stream sweeps the whole map at random
  a_ioreg_route: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R1
    io_req && io_addr <= 32'h0003_FFFF
      |=> io_dec.valid && io_dec.target == imd_pkg::IMD_TGT_IOREG)
    else $error("low region not routed to io registers");

  a_long_rom0: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R2
    io_req && io_addr >= 32'h0004_0000 && io_addr <= 32'h0004_7FFF
      |=> io_dec.valid && io_dec.target == imd_pkg::IMD_TGT_ROM0
      && io_dec.view == imd_pkg::IMD_VIEW_LONG
      && io_dec.offset == 20'($past(io_addr) - 32'h0004_0000))
    else $error("long view block 0 rom wrong");

  a_long_sram0: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R2
    io_req && io_addr >= 32'h0004_C000 && io_addr <= 32'h0004_FFFF
      |=> io_dec.valid && io_dec.target == imd_pkg::IMD_TGT_SRAM0
      && io_dec.view == imd_pkg::IMD_VIEW_LONG
      && io_dec.offset == 20'($past(io_addr) - 32'h0004_C000))
    else $error("long view block 0 sram wrong");

  a_long_sram1: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R2
    pm_req && pm_addr == 32'h0005_C000 |=> pm_dec.target == imd_pkg::IMD_TGT_SRAM1
      && pm_dec.view == imd_pkg::IMD_VIEW_LONG && pm_dec.offset == 20'h00000)
    else $error("long view block 1 sram start wrong");

  a_normal_rom0: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R3
    io_req && io_addr >= 32'h0008_AAAA && io_addr <= 32'h0008_FFFF
      |=> io_dec.valid && io_dec.target == imd_pkg::IMD_TGT_ROM0
      && io_dec.view == imd_pkg::IMD_VIEW_NORMAL
      && io_dec.offset == 20'($past(io_addr) - 32'h0008_0000))
    else $error("normal view block 0 rom wrong");

  a_normal_sram0: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R3
    io_req && io_addr >= 32'h0009_8000 && io_addr <= 32'h0009_FFFF
      |=> io_dec.valid && io_dec.target == imd_pkg::IMD_TGT_SRAM0
      && io_dec.view == imd_pkg::IMD_VIEW_NORMAL
      && io_dec.offset == 20'($past(io_addr) - 32'h0009_8000))
    else $error("normal view block 0 sram wrong");

  a_normal_sram2: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R3
    io_req && io_addr >= 32'h000C_2AAA && io_addr <= 32'h000C_3FFF
      |=> io_dec.valid && io_dec.target == imd_pkg::IMD_TGT_SRAM2
      && io_dec.view == imd_pkg::IMD_VIEW_NORMAL
      && io_dec.offset == 20'($past(io_addr) - 32'h000C_0000))
    else $error("normal view block 2 sram wrong");

  a_short_rom0: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R4
    io_req && io_addr >= 32'h0010_0000 && io_addr <= 32'h0011_FFFF
      |=> io_dec.valid && io_dec.target == imd_pkg::IMD_TGT_ROM0
      && io_dec.view == imd_pkg::IMD_VIEW_SHORT
      && io_dec.offset == 20'($past(io_addr) - 32'h0010_0000))
    else $error("short view block 0 rom wrong");

  a_short_sram0: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R4
    io_req && io_addr >= 32'h0013_0000 && io_addr <= 32'h0013_FFFF
      |=> io_dec.valid && io_dec.target == imd_pkg::IMD_TGT_SRAM0
      && io_dec.view == imd_pkg::IMD_VIEW_SHORT
      && io_dec.offset == 20'($past(io_addr) - 32'h0013_0000))
    else $error("short view block 0 sram wrong");

  a_short_sram3: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R4
    io_req && io_addr >= 32'h001C_0000 && io_addr <= 32'h001C_7FFF
      |=> io_dec.valid && io_dec.target == imd_pkg::IMD_TGT_SRAM3
      && io_dec.view == imd_pkg::IMD_VIEW_SHORT
      && io_dec.offset == 20'($past(io_addr) - 32'h001C_0000))
    else $error("short view block 3 sram wrong");

  // the 48-bit view overlaps the normal one and must win where both hold the address
  a_ext_rom0: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R5
    io_req && io_addr >= 32'h0008_0000 && io_addr <= 32'h0008_AAA9
      |=> io_dec.valid && io_dec.target == imd_pkg::IMD_TGT_ROM0
      && io_dec.view == imd_pkg::IMD_VIEW_EXT
      && io_dec.offset == 20'($past(io_addr) - 32'h0008_0000))
    else $error("extended view block 0 rom wrong");

  a_ext_sram0: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R5
    io_req && io_addr >= 32'h0009_0000 && io_addr <= 32'h0009_5554
      |=> io_dec.valid && io_dec.target == imd_pkg::IMD_TGT_SRAM0
      && io_dec.view == imd_pkg::IMD_VIEW_EXT
      && io_dec.offset == 20'($past(io_addr) - 32'h0009_0000))
    else $error("extended view block 0 sram wrong");

  a_ext_sram3: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R5
    io_req && io_addr >= 32'h000E_0000 && io_addr <= 32'h000E_2AA9
      |=> io_dec.valid && io_dec.target == imd_pkg::IMD_TGT_SRAM3
      && io_dec.view == imd_pkg::IMD_VIEW_EXT
      && io_dec.offset == 20'($past(io_addr) - 32'h000E_0000))
    else $error("extended view block 3 sram wrong");

  // holes and the space above the map
  a_unmapped_high: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R6
    io_req && (io_addr >= 32'h0020_0000
      || io_addr >= 32'h0018_8000 && io_addr <= 32'h001B_FFFF) |=> !io_dec.valid)
    else $error("reserved address selected a block");

  a_reserved_hole: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R6
    io_req && (io_addr >= 32'h0004_8000 && io_addr <= 32'h0004_BFFF
      || io_addr >= 32'h0009_5555 && io_addr <= 32'h0009_7FFF
      || io_addr >= 32'h000C_4000 && io_addr <= 32'h000D_FFFF)
      |=> !io_dec.valid && io_dec.target == imd_pkg::IMD_TGT_NONE)
    else $error("reserved hole selected a block");

  // per-port service: idle ports answer nothing, busy ones all answer together
  a_idle_io: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R7
    !io_req |=> !io_dec.valid)
    else $error("idle io port showed a valid decode");

  a_idle_core: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R7
    !pm_req && !dm_req |=> !pm_dec.valid && !dm_dec.valid && !pm_fetch_ok && !dual_conflict)
    else $error("idle core ports showed activity");

  a_three_ports: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R8
    pm_req && dm_req && io_req && io_addr <= 32'h0003_FFFF
      && pm_addr >= 32'h0010_0000 && pm_addr <= 32'h0011_FFFF
      |=> io_dec.valid && io_dec.target == imd_pkg::IMD_TGT_IOREG
      && pm_dec.valid && pm_dec.target == imd_pkg::IMD_TGT_ROM0
      && dm_addr == $past(cur_ptr))
    else $error("concurrent accesses not all served");

  // instruction fetch view
  a_fetch_ext: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R14
    pm_req && pm_fetch && pm_addr >= 32'h0008_0000 && pm_addr <= 32'h0008_AAA9
      |=> pm_fetch_ok)
    else $error("fetch in 48-bit view not accepted");

  a_fetch_normal: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R14
    pm_req && pm_addr >= 32'h0008_AAAA && pm_addr <= 32'h0008_FFFF
      |=> !pm_fetch_ok && pm_dec.view == imd_pkg::IMD_VIEW_NORMAL)
    else $error("fetch outside 48-bit view accepted");

  // circular buffer unit
  a_dm_addr_pre: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R12
    dm_req |=> dm_addr == $past(cur_ptr))
    else $error("data bus address is not the pre-modify pointer");

  a_set_load: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R11 R13
    set_load ##1 dm_req && dm_set == $past(set_idx)
      |-> cur_ptr == $past(set_base) && cur_base == $past(set_base)
      && cur_len == $past(set_length))
    else $error("loaded buffer set not in use");

  a_wrap_inside: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R12 R16
    dm_req && cur_len != 32'h0000_0000 && cur_len <= 32'h0100_0000
      && cur_ptr >= cur_base && cur_ptr - cur_base < cur_len && cur_base < 32'h8000_0000
      && dm_modify < 32'sh0100_0000 && dm_modify > -32'sh0100_0000
      && (dm_modify < 0 ? -dm_modify : dm_modify) <= $signed(cur_len)
      |-> next_ptr - cur_base < cur_len)
    else $error("pointer left its circular buffer");

  a_wrap_under: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R13 R16
    dm_req && cur_base == 32'h0000_0000 && cur_len != 32'h0000_0000
      && cur_len <= 32'h0100_0000 && cur_ptr < cur_len
      && dm_modify < 0 && dm_modify > -32'sh0100_0000 && $signed(cur_ptr) + dm_modify < 0
      |-> next_ptr == cur_ptr + cur_len + dm_modify)
    else $error("pointer below a zero base not wrapped");

  a_nowrap_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R16
    dm_req && cur_len == 32'h0000_0000 |-> next_ptr == cur_ptr + dm_modify)
    else $error("zero length buffer wrapped");

  a_conflict_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R15
    pm_req && dm_req && pm_addr == cur_ptr && pm_now.valid
      && pm_now.target != imd_pkg::IMD_TGT_IOREG |=> dual_conflict)
    else $error("same block conflict not flagged");

endmodule

// ==== testbench/imd_io_model.sv ====
// requester model standing in for the io_processor side of the decoder
// assumes one access per cycle at most; no handshake, the decoder never stalls
`timescale 1ns/1ns
module imd_io_model (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  output logic             io_req,
  output logic [31:0]      io_addr
);
  int          seed_io;
  logic [31:0] r;

  // ==========================================================
  // request stream
  initial begin
    seed_io = 13;
    io_req  = 1'b0;
    io_addr = 32'h0000_0000;
  end

  // three busy cycles in four on average, so bursts and idle gaps both occur;
  // an idle port still shows a changing address so no stale value is trusted
  always @(posedge ref_clk) begin
    r = $random(seed_io);
    io_req  <= reset_n & (r[1] | r[2]);
    io_addr <= (r[7:3] == 5'h00) ? r : (r & 32'h001F_FFFF);
  end
endmodule

// ==== testbench/imd_decoder_test.sv ====
// self-checking bench for the memory map decoder and its circular buffer unit
// assumes one-cycle registered answers and a 25 MHz ref_clk
`timescale 1ns/1ns
module imd_decoder_test;
  logic ref_clk, reset_n, pm_req, pm_fetch, dm_req, set_load, io_req;
  logic [31:0] pm_addr, set_base, set_length, io_addr, dm_addr;
  logic [4:0] dm_set, set_idx;
  logic signed [31:0] dm_modify;
  logic pm_fetch_ok, dual_conflict;
  imd_pkg::imd_decode_t pm_dec, dm_dec, io_dec, ep, ed;
  int seed, fails, tests_run;
  logic [31:0] m_ptr [32], m_base [32], m_len [32], nx;
  logic p_pm, p_fe, p_dm, p_io, p_cor, cur_cor;
  logic [31:0] p_pa, p_da, p_ia;
  logic [5:0] p_code, cur_code;
  // target and view codes of hand-picked boundary addresses
  localparam logic [31:0] C_ADDR [13] = '{32'h0003_FFFF, 32'h0004_7FFF, 32'h0004_8000,
    32'h0005_C000, 32'h0008_AAA9, 32'h0008_AAAA, 32'h000C_3FFF, 32'h0013_FFFF,
    32'h001C_7FFF, 32'h001B_0000, 32'h0020_0000, 32'hFFFF_FFFF, 32'h000E_2AA9};
  localparam logic [5:0] C_CODE [13] = '{6'h09, 6'h12, 6'h00, 6'h2A, 6'h13, 6'h14, 6'h34,
    6'h1D, 6'h3D, 6'h00, 6'h00, 6'h00, 6'h3B};

  imd_decoder imd_decoder_inst (.ref_clk(ref_clk), .reset_n(reset_n), .pm_req(pm_req),
    .pm_addr(pm_addr), .pm_fetch(pm_fetch), .dm_req(dm_req), .dm_set(dm_set),
    .dm_modify(dm_modify), .set_load(set_load), .set_idx(set_idx), .set_base(set_base),
    .set_length(set_length), .io_req(io_req), .io_addr(io_addr), .pm_dec(pm_dec),
    .dm_dec(dm_dec), .io_dec(io_dec), .dm_addr(dm_addr), .pm_fetch_ok(pm_fetch_ok),
    .dual_conflict(dual_conflict));
  imd_io_model imd_io_model_inst (.ref_clk(ref_clk), .reset_n(reset_n), .io_req(io_req),
    .io_addr(io_addr));

  // ==========================================================
  // expectations and reporting
  // first listed window wins, so the search runs backwards
  function automatic imd_pkg::imd_decode_t exp_dec(input logic [31:0] a);
    imd_pkg::imd_decode_t e;
    logic [31:0] d;
    e = '0;
    for (int k = imd_pkg::IMD_WIN_COUNT - 1; k >= 0; k--) begin
      if (a >= imd_pkg::IMD_WIN_LO[k] && a <= imd_pkg::IMD_WIN_HI[k]) begin
        d = a - imd_pkg::IMD_WIN_LO[k];
        e = '{1'b1, imd_pkg::IMD_WIN_TGT[k], imd_pkg::IMD_WIN_VIEW[k], d[19:0]};
      end
    end
    return e;
  endfunction
  function automatic logic [31:0] rnd_addr();
    logic [31:0] r;
    r = $random(seed);
    return (r[4:0] == 5'h00) ? r : (r & 32'h001F_FFFF);
  endfunction
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      fails++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  task automatic cmp_dec(input imd_pkg::imd_decode_t got, input logic req, input logic [31:0] a);
    imd_pkg::imd_decode_t e;
    e = exp_dec(a);
    check(got.valid === (req & e.valid), "decode valid");
    if (req) check({got.target, got.view} === {e.target, e.view}, "decode target or view");
    if (req && e.valid) check(got.offset === e.offset, "decode offset");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // clock, reset and stimulus
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    logic [31:0] r;
    logic [4:0]  s;
    seed = 13; fails = 0; tests_run = 0; reset_n = 1'b0;
    {pm_req, pm_fetch, dm_req, set_load, cur_cor, p_pm, p_dm, p_io, p_cor} = '0;
    {pm_addr, set_base, set_length, dm_modify, dm_set, set_idx, cur_code} = '0;
    for (int k = 0; k < 32; k++) {m_ptr[k], m_base[k], m_len[k]} = '0;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    // boundary addresses first, as back-to-back fetches, then random traffic
    for (int i = 0; i < 3000; i++) begin
      @(posedge ref_clk);
      r = $random(seed);
      s = 5'($random(seed));
      cur_cor  <= (i < 13);
      cur_code <= C_CODE[i % 13];
      pm_req   <= (i < 13) | r[0];
      pm_fetch <= (i < 13) | r[1];
      // half the random fetches reuse the buffer pointer so both buses share a block
      pm_addr  <= (i < 13) ? C_ADDR[i % 13] : (r[14] ? m_ptr[s] : rnd_addr());
      dm_req   <= r[2] | r[3];
      dm_set   <= s;
      dm_modify <= 32'($signed(r[31:27]));
      // loads never hit the set being stepped in the same cycle
      set_load <= (r[6:4] == 3'h0);
      set_idx  <= s ^ 5'($random(seed) | 1);
      // a zero base now and then lets a negative step pass address zero
      set_base <= (r[15] & r[16]) ? 32'h0000_0000
                                  : ((rnd_addr() & 32'h001F_FFFF) | 32'h0000_1000);
      set_length <= r[7] ? 32'h0000_0000 : 32'h0000_0010 + 32'(r[13:8]);
    end
    @(posedge ref_clk);
    give_verdict();
  end

  // ==========================================================
  // check last cycle's answers, then record this cycle's requests
  always @(negedge ref_clk) begin
    if (reset_n) begin
      cmp_dec(pm_dec, p_pm, p_pa);
      cmp_dec(io_dec, p_io, p_ia);
      cmp_dec(dm_dec, p_dm, p_da);
      if (p_dm) check(dm_addr === p_da, "buffer pointer");
      ep = exp_dec(p_pa);
      ed = exp_dec(p_da);
      check(pm_fetch_ok === (p_pm & p_fe & (ep.view == imd_pkg::IMD_VIEW_EXT)), "fetch");
      check(dual_conflict === (p_pm & p_dm & ep.valid & ed.valid & (ep.target == ed.target)
        & (ep.target != imd_pkg::IMD_TGT_IOREG)), "conflict");
      if (p_cor) check({pm_dec.target, pm_dec.view} === p_code, "boundary");
      {p_pm, p_fe, p_pa, p_io, p_ia, p_dm} = {pm_req, pm_fetch, pm_addr, io_req, io_addr, dm_req};
      {p_cor, p_code, p_da} = {cur_cor, cur_code, m_ptr[dm_set]};
      if (dm_req) begin
        nx = m_ptr[dm_set] + 32'(dm_modify);
        // a negative step that wraps past address zero has left the buffer below its base
        if (m_len[dm_set] != 0
            && (nx < m_base[dm_set] || (dm_modify < 0 && nx > m_ptr[dm_set])))
          nx += m_len[dm_set];
        else if (m_len[dm_set] != 0 && nx >= m_base[dm_set] + m_len[dm_set]) nx -= m_len[dm_set];
        m_ptr[dm_set] = nx;
      end
      if (set_load) {m_ptr[set_idx], m_base[set_idx], m_len[set_idx]} = {set_base, set_base,
        set_length};
    end
  end
endmodule
